/* verilog/asr_host.sv */
// host controller that drives a 4k x 1 asynchronous static ram
//
// Overview of operation
// - read: chip select low, write strobe high; device drives output.
// - write: chip select and strobe both low; output stays high-z.
// - address must be valid no later than chip select falling on read.
// - each read cycle lasts at least 10 ns of stable address.
// - each write cycle lasts at least 10 ns of stable address.
// - select held low at least 8 ns before write ends.
// - address stable at least 8 ns before write ends.
// - address held to the end of write, zero hold after.
// - write data valid 5 ns before write end and held to it.
module asr_host
  import asr_pkg::*;
#(
  parameter int WP_CYCLES = WP_CYC,
  parameter int RD_CYCLES = RD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  output logic req_ready,
  input wire asr_req_t req,
  output logic rd_valid,
  output logic rd_data,
  output asr_pins_t pins,
  input wire logic sram_dout
);
  // counts must fit the 4-bit down counter and meet the pin minimums
  if (WP_CYCLES < WP_CYC || WP_CYCLES > 15 ||
      RD_CYCLES < RD_CYC || RD_CYCLES > 15) begin : g_bad_cycles
    $error("asr_host: cycle counts out of range");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RD   = 4'b0010,
    S_WR   = 4'b0100,
    S_REC  = 4'b1000
  } asr_state_t;

  asr_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  asr_pins_t pins_r, pins_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic rd_data_r, rd_data_nxt;

  assign req_ready = (state_r == S_IDLE);
  assign pins = pins_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pins_nxt = pins_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    case (state_r)
      S_IDLE: begin
        if (req_valid) begin
          // address and data launch with the select edge, never after
          pins_nxt.addr = req.addr;
          pins_nxt.din = req.wdata;
          pins_nxt.cs_n = 1'b0;
          pins_nxt.we_n = ~req.write;
          if (req.write) begin
            state_nxt = S_WR;
            cnt_nxt = 4'(WP_CYCLES - 1);
          end else begin
            state_nxt = S_RD;
            cnt_nxt = 4'(RD_CYCLES - 1);
          end
        end
      end
      S_RD: begin
        if (cnt_r == CNT_ZERO) begin
          // sample after full access time plus one margin cycle
          rd_data_nxt = sram_dout;
          rd_valid_nxt = 1'b1;
          pins_nxt.cs_n = 1'b1;
          state_nxt = S_REC;
          cnt_nxt = 4'(REC_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      S_WR: begin
        if (cnt_r == CNT_ZERO) begin
          // both rise together: address and data held through the edge
          pins_nxt.cs_n = 1'b1;
          pins_nxt.we_n = 1'b1;
          state_nxt = S_REC;
          cnt_nxt = 4'(REC_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      S_REC: begin
        // gap lets the device float its output before the next select
        if (cnt_r == CNT_ZERO) begin
          state_nxt = S_IDLE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        state_nxt = S_IDLE;
        pins_nxt.cs_n = 1'b1;
        pins_nxt.we_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= S_IDLE;
      cnt_r <= CNT_ZERO;
      pins_r <= '{addr: '0, cs_n: 1'b1, we_n: 1'b1, din: 1'b0};
      rd_valid_r <= 1'b0;
      rd_data_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  property p_wr_pulse;
    @(posedge clk_sys) disable iff (rst || !ce)
      $fell(pins.we_n) |-> !pins.cs_n ##1 $stable(pins.addr);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe fell without select");

  property p_addr_hold_wr;
    @(posedge clk_sys) disable iff (rst || !ce)
      !pins.we_n |=> $stable(pins.addr) && $stable(pins.din);
  endproperty
  a_addr_hold_wr: assert property (p_addr_hold_wr)
    else $error("address or data moved during write");

  property p_rise_together;
    @(posedge clk_sys) disable iff (rst || !ce)
      $rose(pins.we_n) |-> $rose(pins.cs_n);
  endproperty
  a_rise_together: assert property (p_rise_together)
    else $error("strobe rose without select");

  property p_we_only_with_cs;
    @(posedge clk_sys) disable iff (rst)
      !pins.we_n |-> !pins.cs_n;
  endproperty
  a_we_only_with_cs: assert property (p_we_only_with_cs)
    else $error("write strobe low while deselected");

  property p_rd_addr_stable;
    @(posedge clk_sys) disable iff (rst || !ce)
      !pins.cs_n && pins.we_n && !$past(pins.cs_n) |-> $stable(pins.addr);
  endproperty
  a_rd_addr_stable: assert property (p_rd_addr_stable)
    else $error("address moved during read");

  property p_rd_len;
    @(posedge clk_sys) disable iff (rst || !ce)
      $fell(pins.cs_n) && pins.we_n |-> !pins.cs_n [*2];
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read select shorter than access time");

  property p_rd_valid;
    @(posedge clk_sys) disable iff (rst || !ce)
      $rose(rd_valid) |-> $rose(pins.cs_n) && pins.we_n;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read result without ending read cycle");

  property p_gap;
    @(posedge clk_sys) disable iff (rst || !ce)
      $rose(pins.cs_n) |=> pins.cs_n;
  endproperty
  a_gap: assert property (p_gap)
    else $error("select reasserted without recovery");

  // a taken request shows on the pins at the very next sample
  property p_take;
    @(posedge clk_sys) disable iff (rst || !ce)
      req_valid && req_ready |=> !pins.cs_n &&
      pins.we_n == !$past(req.write) && pins.addr == $past(req.addr) &&
      pins.din == $past(req.wdata);
  endproperty
  a_take: assert property (p_take)
    else $error("request not launched onto the pins");

  property p_idle_pins;
    @(posedge clk_sys) disable iff (rst || !ce)
      req_ready |-> pins.cs_n && pins.we_n;
  endproperty
  a_idle_pins: assert property (p_idle_pins)
    else $error("pins not idle while ready");

  property p_rd_we_high;
    @(posedge clk_sys) disable iff (rst || !ce)
      $fell(pins.cs_n) && pins.we_n |=> pins.we_n;
  endproperty
  a_rd_we_high: assert property (p_rd_we_high)
    else $error("write strobe fell during read");

  // result only moves with a fresh read pulse
  property p_rd_data_hold;
    @(posedge clk_sys) disable iff (rst || !ce)
      $changed(rd_data) |-> $rose(rd_valid);
  endproperty
  a_rd_data_hold: assert property (p_rd_data_hold)
    else $error("read data moved without a read result");
endmodule

/* verilog/asr_pkg.sv */
// package: pin timing, geometry and carrier types for the 4k x 1 sram host
package asr_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_BITS = 12;
  localparam int DEPTH = 4096;
  // timing figures in ns (minimum values unless noted)
  localparam int T_RC_NS = 10;
  localparam int T_WC_NS = 10;
  localparam int T_CW_NS = 8;
  localparam int T_AW_NS = 8;
  localparam int T_WP_NS = 8;
  localparam int T_DW_NS = 5;
  localparam int T_ACC_NS = 10; // maximum, covers address_to_data_delay too
  localparam int T_HZ_NS = 4;   // maximum
  localparam int T_WZ_NS = 5;   // maximum
  localparam int T_OH_NS = 2;
  localparam int T_PD_NS = 10;  // maximum
  // least times round up, never below one cycle
  function automatic int ns_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int WP_CYC = ns_up(T_WP_NS);
  localparam int RD_CYC = ns_up(T_ACC_NS) + 1;
  localparam int REC_CYC = ns_up(T_HZ_NS);
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    logic cs_n;
    logic we_n;
    logic din;
  } asr_pins_t;

  typedef struct packed {
    logic write;
    logic [ADDR_BITS-1:0] addr;
    logic wdata;
  } asr_req_t;
endpackage

/* bench/asr_sram_model.sv */
// behavioural 4k x 1 async sram answering the host's pins
module asr_sram_model
  import asr_pkg::*;
(
  input wire asr_pins_t pins,
  output logic dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mem [DEPTH];
  logic wr_q;
  logic d_q;
  logic last;
  logic active;
  logic [ADDR_BITS-1:0] a_q;
  // one process keeps latch, capture and output in a fixed order
  initial begin
    for (int i = 0; i < DEPTH; i++) mem[i] = i[0];
    wr_q = 0;
    last = 0;
    active = 0;
    dout = 1;
    forever begin
      @(pins);
      if (wr_q && (pins.cs_n || pins.we_n)) mem[a_q] = d_q;
      wr_q = !pins.cs_n && !pins.we_n;
      if (wr_q) a_q = pins.addr;
      if (wr_q) d_q = pins.din;
      if (!pins.cs_n) active = 1'b1; // no power-up delay
      else active <= #(T_PD_NS) 1'b0;
      if (!pins.cs_n && active && pins.we_n) begin
        dout <= #(T_OH_NS) ~last; // old value held briefly
        last = mem[pins.addr];
        dout <= #(T_ACC_NS) last; // slowest legal answer
      end else begin
        dout = ~last; // no pull, so not the old bit
      end
    end
  end
endmodule

/* bench/asr_host_tb.sv */
// self-checking bench for the sram host controller
module asr_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import asr_pkg::*;
  logic clk_sys, rst, ce, req_valid, rd_valid, rd_data, req_ready, dout;
  logic ce_rnd;
  asr_req_t req;
  asr_pins_t pins;
  logic shadow [DEPTH];
  int seed, err_total, compares;
  asr_host #(.WP_CYCLES(WP_CYC), .RD_CYCLES(RD_CYC)) u_dut (.clk_sys(clk_sys),
    .rst(rst), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins),
    .sram_dout(dout));
  asr_sram_model u_mem (.pins(pins), .dout(dout));
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [14:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic exp_bit(input logic [11:0] a);
    return shadow[a];
  endfunction
  task automatic print_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic d);
    int n;
    n = 0;
    req_valid = 1;
    req = {w, a, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(req_ready === 1'b1 && ce === 1'b1) && n < 50);
    #1 req_valid = 0;
    check("take", 15'(n < 50), 15'h0001);
    check("pins", pins[14:1], {a, 1'b0, !w});
    if (w) check("din", pins.din, d);
    if (w) shadow[a] = d;
    n = 0;
    while (!w && rd_valid !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (!w) check("rd wait", 15'(n < 50), 15'h0001);
    if (!w && !ce_rnd) check("latency", 15'(n), 15'(RD_CYC));
    if (!w) check("rd_data", rd_data, exp_bit(a));
    @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys) begin
    #1 ce = ce_rnd ? ($random(seed) % 4 != 0) : 1'b1;
    if (!rst && pins.we_n === 1'b0) check("cs_n", pins.cs_n, 1'b0);
  end
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
  initial begin
    logic [11:0] c [4];
    c = '{12'h000, 12'hfff, 12'haaa, 12'h555};
    seed = 47318;
    rst = 1;
    ce_rnd = 0;
    req_valid = 0;
    req = '0;
    err_total = 0;
    compares = 0;
    for (int i = 0; i < DEPTH; i++) shadow[i] = i[0];
    repeat (10) @(posedge clk_sys);
    #1 rst = 0;
    check("pins reset", pins, 15'h0006);
    check("ready", req_ready, 1'b1);
    // corners: both ends of the space and the two alternating patterns, all four written, then all four read
    foreach (c[i]) xfer(1, c[i], ~c[i][0]);
    foreach (c[i]) xfer(0, c[i], 0);
    for (int k = 0; k < 300; k++) begin
      if (k == 150) ce_rnd = 1;
      xfer(1'($random(seed)), 12'($random(seed)),
        1'($random(seed)));
    end
    ce_rnd = 0;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1;
    repeat (2) @(posedge clk_sys);
    #1 check("pins mid reset", pins, 15'h0006);
    check("rd_valid", rd_valid, 1'b0);
    rst = 0;
    // contents survive controller reset, nothing refreshed
    foreach (c[i]) xfer(0, c[i], 0);
    print_verdict();
  end
endmodule
